// >>> shared/spi_master_consts.svh
// Constants for the serial unit in SPI master mode
`ifndef SPI_MASTER_CONSTS_SVH
`define SPI_MASTER_CONSTS_SVH
`define MODE_SPI_MASTER 2'h3
`define BAUD_RESET 12'h000
`define BAUD_WIDTH 12
`define BITS_PER_BYTE 4'h8
`endif

// >>> shared/spi_master_pkg.sv
// Types for the serial unit in SPI master mode
`default_nettype none
package spi_master_pkg;
  typedef struct packed {
    logic [1:0] serial_mode_select;
    logic clock_polarity_select;
    logic clock_phase_select;
    logic data_order_select;
    logic transmitter_enable;
    logic receiver_enable;
  } frame_cfg_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LEAD = 3'b010,
    ST_TRAIL = 3'b100
  } xfer_state_e;
endpackage : spi_master_pkg
`default_nettype wire

// >>> hw/baud_divider_gen.sv
// Baud divider producing one-cycle half-bit enable pulses
`timescale 1ns/10ps
`default_nettype none
`include "spi_master_consts.svh"
module baud_divider_gen #(
  parameter int WIDTH = `BAUD_WIDTH
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  input wire logic [WIDTH-1:0] baud_divider_i,
  output logic tick_o
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic tick_d;
  // Half period is divider+1 clocks: rate f/(2(div+1)), at most f/2
  always_comb
  begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!run_i)
    begin
      cnt_d = '0;
    end
    else if (cnt_q >= baud_divider_i)
    begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q + WIDTH'(1);
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_o <= tick_d;
    end
  end
endmodule : baud_divider_gen
`default_nettype wire

// >>> hw/serial_master_spi_unit.sv
// Serial unit operating as SPI master with double-buffered transmit
`timescale 1ns/10ps
`default_nettype none
`include "spi_master_consts.svh"
// Operation
// [RL1] Mode select both ones makes the unit an SPI master.
// [RL2] No parity, recovery or async controllers in this mode.
// [RL3] All four clock modes via polarity and phase bits.
// [RL4] One data-order bit picks LSB or MSB first for both directions.
// [RL5] Changing data order mid-transfer corrupts it; nothing guards against it.
// [RL6] Transmit is double buffered; next byte may be written while shifting.
// [RL7] Serial clock rate is clock over two times divider plus one.
// [RL8] Fastest serial clock is half the system clock.
// [RL9] Only internal clock; always master, never slave.
// [RL10] Software sets the clock pin direction to output first.
// [RL11] Divider held zero at enable, then loaded before first transfer.
// [RL12] Baud divider resets to zero.
// [RL13] Two queued bytes form 16 bits; transmit complete after both.
// [RL14] Transmitter runs alone; receiver needs the transmitter enabled.
// [RL15] Software changes settings only while idle.
// [RL16] Software clears transmit complete before each data write.
// [RL17] Full duplex; one bit out and one bit in per clock period.
// [RL18] Software disables interrupts globally during initialization.
// [RL19] Polarity sets idle clock; phase picks leading or trailing sample edge.
// [RL20] Receive complete set on full byte, cleared on data read.
module serial_master_spi_unit #(
  parameter int BAUD_W = `BAUD_WIDTH
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire spi_master_pkg::frame_cfg_s cfg_i,
  input wire logic baud_wr_i,
  input wire logic [BAUD_W-1:0] baud_wdata_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_wdata_i,
  input wire logic data_rd_i,
  input wire logic txc_clr_i,
  input wire logic miso_i,
  output logic serial_clock_pin_o,
  output logic mosi_o,
  output logic [7:0] data_rdata_o,
  output logic buffer_empty_o,
  output logic transmit_complete_flag_o,
  output logic receive_complete_flag_o,
  output logic [BAUD_W-1:0] baud_divider_o
);
  spi_master_pkg::xfer_state_e st_q, st_d;
  logic active;
  logic tx_on;
  logic tick;
  logic [BAUD_W-1:0] baud_q, baud_d;
  logic [7:0] buf_q, buf_d;
  logic buf_full_q, buf_full_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] rx_q, rx_d;
  logic [3:0] cnt_q, cnt_d;
  logic sck_q, sck_d;
  logic mosi_q, mosi_d;
  logic miso_q, miso_d;
  logic txc_q, txc_d;
  logic rxc_q, rxc_d;
  logic [7:0] rd_q, rd_d;
  logic byte_done;

  function automatic logic out_bit(input logic [7:0] v, input logic lsb_first);
    out_bit = lsb_first ? v[0] : v[7];
  endfunction : out_bit

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic lsb_first,
                                         input logic b);
    shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
  endfunction : shift_in

  assign active = (cfg_i.serial_mode_select == `MODE_SPI_MASTER); // RL1 RL2 RL9
  assign tx_on = active && cfg_i.transmitter_enable; // RL14

  baud_divider_gen #(
    .WIDTH(BAUD_W)
  ) u_baud (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(st_q != spi_master_pkg::ST_IDLE),
    .baud_divider_i(baud_q), // RL7 RL8
    .tick_o(tick)
  );

  always_comb
  begin
    st_d = st_q;
    baud_d = baud_wr_i ? baud_wdata_i : baud_q;
    buf_d = buf_q;
    buf_full_d = buf_full_q;
    sh_d = sh_q;
    rx_d = rx_q;
    cnt_d = cnt_q;
    sck_d = sck_q;
    mosi_d = mosi_q;
    miso_d = miso_q;
    txc_d = txc_q;
    rxc_d = rxc_q;
    rd_d = rd_q;
    byte_done = 1'b0;
    if (data_wr_i && tx_on)
    begin
      buf_d = data_wdata_i; // RL6
      buf_full_d = 1'b1;
    end
    if (txc_clr_i)
    begin
      txc_d = 1'b0;
    end
    if (data_rd_i)
    begin
      rxc_d = 1'b0; // RL20
    end
    case (st_q)
      spi_master_pkg::ST_IDLE:
      begin
        sck_d = cfg_i.clock_polarity_select; // RL19
        if (tx_on && buf_full_q)
        begin
          sh_d = buf_q;
          buf_full_d = data_wr_i;
          cnt_d = '0;
          mosi_d = out_bit(buf_q, cfg_i.data_order_select); // RL4
          st_d = spi_master_pkg::ST_LEAD;
        end
      end
      spi_master_pkg::ST_LEAD:
      begin
        if (tick)
        begin
          sck_d = ~sck_q; // RL3
          if (!cfg_i.clock_phase_select)
          begin
            miso_d = miso_i; // RL19
          end
          else
          begin
            mosi_d = out_bit(sh_q, cfg_i.data_order_select);
          end
          st_d = spi_master_pkg::ST_TRAIL;
        end
      end
      spi_master_pkg::ST_TRAIL:
      begin
        if (tick)
        begin
          sck_d = ~sck_q;
          // Data order read live each bit, so changing it mid-byte corrupts
          rx_d = shift_in(rx_q, cfg_i.data_order_select,
                          cfg_i.clock_phase_select ? miso_i : miso_q); // RL5 RL17
          sh_d = shift_in(sh_q, cfg_i.data_order_select, 1'b0);
          cnt_d = cnt_q + 4'h1;
          st_d = spi_master_pkg::ST_LEAD;
          if (!cfg_i.clock_phase_select)
          begin
            mosi_d = out_bit(shift_in(sh_q, cfg_i.data_order_select, 1'b0),
                             cfg_i.data_order_select);
          end
          if (cnt_q == `BITS_PER_BYTE - 4'h1)
          begin
            byte_done = 1'b1;
            if (buf_full_q && tx_on)
            begin
              sh_d = buf_q; // RL13
              buf_full_d = data_wr_i;
              cnt_d = '0;
              if (!cfg_i.clock_phase_select)
              begin
                mosi_d = out_bit(buf_q, cfg_i.data_order_select);
              end
            end
            else
            begin
              st_d = spi_master_pkg::ST_IDLE;
              txc_d = 1'b1; // RL13
            end
          end
        end
      end
      default:
      begin
        st_d = spi_master_pkg::ST_IDLE;
      end
    endcase
    if (byte_done && cfg_i.receiver_enable)
    begin
      rd_d = shift_in(rx_q, cfg_i.data_order_select,
                      cfg_i.clock_phase_select ? miso_i : miso_q);
      rxc_d = 1'b1; // RL20
    end
    if (!tx_on)
    begin
      st_d = spi_master_pkg::ST_IDLE;
      buf_full_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_q <= spi_master_pkg::ST_IDLE;
      baud_q <= `BAUD_RESET; // RL12
      buf_q <= 8'h00;
      buf_full_q <= 1'b0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      cnt_q <= 4'h0;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
      miso_q <= 1'b0;
      txc_q <= 1'b0;
      rxc_q <= 1'b0;
      rd_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      baud_q <= baud_d;
      buf_q <= buf_d;
      buf_full_q <= buf_full_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      cnt_q <= cnt_d;
      sck_q <= sck_d;
      mosi_q <= mosi_d;
      miso_q <= miso_d;
      txc_q <= txc_d;
      rxc_q <= rxc_d;
      rd_q <= rd_d;
    end
  end

  assign serial_clock_pin_o = sck_q;
  assign mosi_o = mosi_q;
  assign data_rdata_o = rd_q;
  assign buffer_empty_o = ~buf_full_q;
  assign transmit_complete_flag_o = txc_q;
  assign receive_complete_flag_o = rxc_q;
  assign baud_divider_o = baud_q;

  a_idle_clock: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q == spi_master_pkg::ST_IDLE && $past(st_q) == spi_master_pkg::ST_IDLE &&
    $past(rst_b_i))
    |-> sck_q == $past(cfg_i.clock_polarity_select)) // RL19
    else $error("idle clock level wrong");
  a_baud_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(rst_b_i) |-> baud_q == '0) // RL12
    else $error("divider not zero after reset");
  a_txc_on_done: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q == spi_master_pkg::ST_TRAIL && st_d == spi_master_pkg::ST_IDLE && tx_on)
    |=> txc_q) // RL13
    else $error("transmit complete missing");
  a_rxc_on_byte: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (byte_done && cfg_i.receiver_enable) |=> rxc_q) // RL20
    else $error("receive complete missing");
  a_rxc_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (data_rd_i && !(byte_done && cfg_i.receiver_enable)) |=> !rxc_q) // RL20
    else $error("receive complete not cleared");
  a_no_tx_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !tx_on |=> st_q == spi_master_pkg::ST_IDLE) // RL14
    else $error("shifting without transmitter");
  a_edge_on_tick: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q != spi_master_pkg::ST_IDLE && tx_on && !tick) |=> $stable(sck_q)) // RL7
    else $error("clock toggled without tick");
  a_max_rate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q != spi_master_pkg::ST_IDLE && $changed(sck_q)) |=>
    (baud_q == '0 || $stable(sck_q))) // RL8
    else $error("clock faster than half rate");
  a_queue_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q == spi_master_pkg::ST_IDLE && tx_on && buf_full_q) |=>
    st_q == spi_master_pkg::ST_LEAD) // RL6
    else $error("queued byte not started");
  c_byte: cover property (@(posedge clk_i) disable iff (!rst_b_i) byte_done);
  c_back_to_back: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    byte_done && buf_full_q);
  c_mode3: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    byte_done && cfg_i.clock_polarity_select && cfg_i.clock_phase_select);
endmodule : serial_master_spi_unit
`default_nettype wire

// >>> testbench/spi_slave_model.sv
// Behavioural SPI slave on the far side of the serial unit
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic lsb_i,
  input wire logic restart_i,
  input wire logic [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o,
  output logic [15:0] cnt_o
);
  logic [7:0] sh;
  logic [7:0] tx;
  int n;
  function automatic logic pick(input int k);
    return lsb_i ? tx[k] : tx[7-k];
  endfunction : pick
  initial
  begin
    miso_o = 1'b0;
    cnt_o = 16'h0000;
  end
  always @(posedge restart_i)
  begin
    n = 0;
    tx = tx_i;
    miso_o = pick(0);
  end
  // Sample on leading edge in phase 0, on trailing edge in phase 1
  always @(sck_i)
  begin
    if (restart_i !== 1'b1 && ((sck_i != cpol_i) != cpha_i))
    begin
      sh = lsb_i ? {mosi_i, sh[7:1]} : {sh[6:0], mosi_i};
      n = n + 1;
      if (n == 8)
      begin
        n = 0;
        rx_o = sh;
        cnt_o = cnt_o + 16'h0001;
        // Released line must not show the stale bit
        if (cpha_i) miso_o = ~miso_o;
      end
    end
    else if (restart_i !== 1'b1)
    begin
      if (n == 0) tx = tx_i;
      miso_o = pick(n);
    end
  end
endmodule : spi_slave_model
`default_nettype wire

// >>> testbench/serial_master_spi_unit_tb.sv
// Self-checking bench for the serial unit in SPI master mode
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("Error at %0t: mismatch", $time); end end
module serial_master_spi_unit_tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  spi_master_pkg::frame_cfg_s cfg = 7'h00;
  logic baud_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0, txc_clr = 1'b0, restart = 1'b0;
  logic [11:0] baud_wdata = 12'h000, baud_q;
  logic [7:0] data_wdata = 8'h00, stx = 8'h00, rdata, srx;
  logic miso, sck, mosi, buf_empty, txc, rxc, sck_prev;
  logic [15:0] cnt;
  int fail_count = 0, samples_checked = 0, seed = 30, half_cnt = 0, last_half = 0;
  logic [7:0] mosi_q[$], miso_q[$];
  always #4 clk_i = ~clk_i;
  serial_master_spi_unit i_serial_master_spi_unit (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_i(cfg), .baud_wr_i(baud_wr),
    .baud_wdata_i(baud_wdata), .data_wr_i(data_wr), .data_wdata_i(data_wdata),
    .data_rd_i(data_rd), .txc_clr_i(txc_clr), .miso_i(miso), .serial_clock_pin_o(sck),
    .mosi_o(mosi), .data_rdata_o(rdata), .buffer_empty_o(buf_empty),
    .transmit_complete_flag_o(txc), .receive_complete_flag_o(rxc), .baud_divider_o(baud_q));
  spi_slave_model i_spi_slave_model (
    .sck_i(sck), .mosi_i(mosi), .cpol_i(cfg.clock_polarity_select),
    .cpha_i(cfg.clock_phase_select), .lsb_i(cfg.data_order_select), .restart_i(restart),
    .tx_i(stx), .miso_o(miso), .rx_o(srx), .cnt_o(cnt));
  // Clock edges between serial clock toggles
  always @(posedge clk_i)
  begin
    if (sck !== sck_prev)
    begin
      last_half = half_cnt;
      half_cnt = 1;
    end
    else half_cnt = half_cnt + 1;
    sck_prev = sck;
  end
  always @(cnt)
  begin
    if ($time > 0) `CHK(srx, mosi_q.pop_front())
  end
  // Reads each received byte like software would
  always @(posedge clk_i)
  begin
    if (rxc === 1'b1)
    begin
      `CHK(rdata, miso_q.pop_front())
      #1 data_rd = 1'b1;
      @(posedge clk_i);
      #1 data_rd = 1'b0;
      `CHK(rxc, 1'b0)
    end
  end
  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic pulse(input int which);
    case (which)
      0: baud_wr = 1'b1;
      1: data_wr = 1'b1;
      default: txc_clr = 1'b1;
    endcase
    @(posedge clk_i);
    #1 {baud_wr, data_wr, txc_clr} = 3'h0;
  endtask : pulse
  task automatic wait_for(input logic want_txc);
    int i;
    for (i = 0; i < 5000; i++)
    begin
      @(posedge clk_i);
      if ((want_txc ? txc : buf_empty) === 1'b1) break;
    end
    if (i == 5000)
    begin
      fail_count++;
      $display("Error at %0t: timeout", $time);
      stop_test();
    end
    #1;
  endtask : wait_for
  task automatic xfer(input logic [11:0] d, input logic two);
    logic [15:0] start;
    baud_wdata = d;
    pulse(0);
    `CHK(baud_q, d)
    stx = 8'($random(seed));
    repeat (4) @(posedge clk_i);
    #1 restart = 1'b1;
    #1 restart = 1'b0;
    pulse(2);
    start = cnt;
    repeat (two ? 2 : 1)
    begin
      repeat (2) @(posedge clk_i);
      wait_for(1'b0);
      data_wdata = 8'($random(seed));
      mosi_q.push_back(data_wdata);
      if (cfg.receiver_enable) miso_q.push_back(stx);
      pulse(1);
    end
    `CHK(txc, 1'b0)
    wait_for(1'b1);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(cnt - start, two ? 16'h0002 : 16'h0001)
    `CHK(last_half, int'(d) + 1)
    `CHK(mosi_q.size() + miso_q.size(), 0)
  endtask : xfer
  initial
  begin
    repeat (12) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    `CHK(baud_q, 12'h000)
    `CHK(sck, 1'b0)
    `CHK({txc, rxc}, 2'h0)
    // Writes dropped outside master mode or with transmitter off
    for (int k = 0; k < 2; k++)
    begin
      cfg = k ? 7'h61 : 7'h23;
      pulse(1);
      repeat (60) @(posedge clk_i);
      #1;
      `CHK({cnt, txc}, 17'h00000)
    end
    for (int m = 0; m < 8; m++)
    begin
      cfg = {2'h3, m[0], m[1], m[2], 1'b1, 1'(m != 3)};
      xfer((m == 0) ? 12'h000 : 12'($random(seed)) & 12'h003, m >= 6);
    end
    stop_test();
  end
endmodule : serial_master_spi_unit_tb
`default_nettype wire
